// >>> inc/cba_pkg.sv
// package: register map, field layout, reset values and timing counts of the clock config bank
package cba_pkg;

   // ---------------------------------------------------------------
   // register offsets and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] OUT_DIS_OFS     = 8'h0A;
   localparam logic [7:0] IN_PD_OFS       = 8'h0B;
   localparam logic [7:0] ALARM_CFG_OFS   = 8'h13;
   localparam logic [7:0] OUT_DIS_RST     = 8'h00;
   localparam logic [7:0] IN_PD_RST       = 8'h40;
   localparam logic [7:0] ALARM_CFG_RST   = 8'h2C;
   localparam logic [7:0] OUT_DIS_WMASK   = 8'h0C;
   localparam logic [7:0] IN_PD_WMASK     = 8'h03;
   localparam logic [7:0] ALARM_CFG_WMASK = 8'hFF;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int OUT2_DIS_BIT  = 3;
   localparam int OUT1_DIS_BIT  = 2;
   localparam int IN2_PD_BIT    = 1;
   localparam int IN1_PD_BIT    = 0;
   localparam int GLB_EN_BIT    = 7;
   localparam int THR_LSB       = 5;
   localparam int VALT_LSB      = 3;
   localparam int LOCK_ONESHOT_INTERVAL_LSB     = 0;
   localparam int OFS_W         = 10;

   // offset thresholds in ppm, alarm when measured offset is above the value
   localparam logic [3:0][OFS_W-1:0] THR_PPM = {10'h0C8, 10'h01E, 10'h030, 10'h00B};

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam real CLK_MHZ   = 250.0;
   localparam real VALT_MS [4] = '{2.0, 100.0, 200.0, 13000.0};
   localparam real LOCK_ONESHOT_INTERVAL_MS[8] = '{106.0, 53.0, 26.5, 13.3, 6.6, 3.3, 1.66, 0.833};
   localparam real CYC_PER_MS = CLK_MHZ * 1000.0;
   // least times, so round up
   localparam logic [3:0][31:0] VALT_CYC = {
      32'($ceil(VALT_MS[3] * CYC_PER_MS)), 32'($ceil(VALT_MS[2] * CYC_PER_MS)),
      32'($ceil(VALT_MS[1] * CYC_PER_MS)), 32'($ceil(VALT_MS[0] * CYC_PER_MS))};
   localparam logic [7:0][31:0] LOCK_ONESHOT_INTERVAL_CYC = {
      32'($ceil(LOCK_ONESHOT_INTERVAL_MS[7] * CYC_PER_MS)), 32'($ceil(LOCK_ONESHOT_INTERVAL_MS[6] * CYC_PER_MS)),
      32'($ceil(LOCK_ONESHOT_INTERVAL_MS[5] * CYC_PER_MS)), 32'($ceil(LOCK_ONESHOT_INTERVAL_MS[4] * CYC_PER_MS)),
      32'($ceil(LOCK_ONESHOT_INTERVAL_MS[3] * CYC_PER_MS)), 32'($ceil(LOCK_ONESHOT_INTERVAL_MS[2] * CYC_PER_MS)),
      32'($ceil(LOCK_ONESHOT_INTERVAL_MS[1] * CYC_PER_MS)), 32'($ceil(LOCK_ONESHOT_INTERVAL_MS[0] * CYC_PER_MS))};

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cba_req_type;

   typedef struct packed {
      logic out2_buf_pd;
      logic out2_div_pd;
      logic out1_buf_pd;
      logic out1_div_pd;
      logic in2_pd;
      logic in1_pd;
   } cba_pd_type;

endpackage

// >>> test/cba_clk_cfg_test.sv
// self-checking bench for the clock config register bank
`timescale 1ns/100ps
module cba_clk_cfg_test;
   import cba_pkg::*;
   // ----------------------------------------------
   // short counts so every interval fits the run
   // ----------------------------------------------
   localparam logic [3:0][31:0] VT = {32'd40, 32'd30, 32'd20, 32'd10};
   localparam logic [7:0][31:0] LT = {32'd10, 32'd20, 32'd30, 32'd40,
                                      32'd50, 32'd60, 32'd70, 32'd80};
   localparam int         THR[4]  = '{11, 48, 30, 200};
   localparam logic [7:0] ADR[3]  = '{OUT_DIS_OFS, IN_PD_OFS, ALARM_CFG_OFS};
   localparam logic [7:0] RSTV[3] = '{OUT_DIS_RST, IN_PD_RST, ALARM_CFG_RST};
   localparam logic [7:0] WM[3]   = '{OUT_DIS_WMASK, IN_PD_WMASK, ALARM_CFG_WMASK};
   logic                       clk_sys = 1'b0;
   logic                       reset = 1'b1;
   cba_req_type                reg_req = '0;
   logic [7:0]                 reg_rdata;
   logic                       reg_rvalid;
   logic [1:0]                 per_en = 2'b00;
   logic [1:0][OFS_W-1:0]      ofs = '0;
   logic                       phase_slip = 1'b0;
   cba_pd_type                 pd;
   logic [1:0]                 alarm;
   logic                       os_act;
   int                         err_total = 0;
   int                         comparisons = 0;
   logic [7:0]                 exp_q[$];
   logic [7:0]                 mdl[3];

   cba_clk_cfg #(.VALT_CYCLES(VT), .LOCK_ONESHOT_INTERVAL_CYCLES(LT)) DUT (
      .clk_sys(clk_sys), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .per_input_offset_enable(per_en), .offset_ppm(ofs),
      .phase_slip(phase_slip), .pd(pd), .frequency_offset_alarm(alarm),
      .lock_oneshot_active(os_act));

   always #2 clk_sys = ~clk_sys;

   // ----------------------------------------------
   // helpers
   // ----------------------------------------------
   task automatic cyc();
      @(posedge clk_sys);
      #1;
   endtask

   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk1(input string nm, input logic e, input logic g);
      chk8(nm, {7'h00, e}, {7'h00, g});
   endtask

   task automatic end_sim();
      $display("checks %0d errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_req.wr = 1'b1;
      reg_req.addr = a;
      reg_req.wdata = d;
      cyc();
      reg_req.wr = 1'b0;
   endtask

   // the monitor pops the note; a read that never answers ends the run
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      int n;
      exp_q.push_back(e);
      reg_req.rd = 1'b1;
      reg_req.addr = a;
      cyc();
      reg_req.rd = 1'b0;
      n = 0;
      while (exp_q.size() != 0 && n < 4) begin
         cyc();
         n++;
      end
      if (exp_q.size() != 0) begin
         err_total++;
         $display("FAIL reg_rvalid expected 1 seen 0");
         end_sim();
      end
   endtask

   always @(posedge clk_sys) begin
      if (reg_rvalid === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk1("reg_rvalid", 1'b0, reg_rvalid);
         end else begin
            chk8("reg_rdata", exp_q.pop_front(), reg_rdata);
         end
      end
   end

   // ----------------------------------------------
   // main sequence
   // ----------------------------------------------
   initial begin
      int j;
      logic [7:0] d;
      void'($urandom(32'hA961));
      repeat (6) cyc();
      reset = 1'b0;
      for (int i = 0; i < 3; i++) begin
         mdl[i] = RSTV[i];
         rd(ADR[i], RSTV[i]);
      end
      rd(8'h55, 8'h00);
      chk8("pd", 8'h00, {2'b00, pd});
      // all ones first so reserved bits are hit, then random traffic
      for (int k = 0; k < 15; k++) begin
         j = (k < 3) ? k : int'($urandom_range(2, 0));
         d = (k < 3) ? 8'hFF : 8'($urandom());
         wr(ADR[j], d);
         mdl[j] = (d & WM[j]) | (RSTV[j] & ~WM[j]);
         cyc();
         chk8("pd", {2'b00, mdl[0][3], mdl[0][3], mdl[0][2], mdl[0][2], mdl[1][1:0]},
              {2'b00, pd});
         rd(ADR[j], mdl[j]);
      end
      // a reset in mid-run must bring back every reset value
      reset = 1'b1;
      repeat (2) cyc();
      reset = 1'b0;
      for (int i = 0; i < 3; i++) begin
         mdl[i] = RSTV[i];
         rd(ADR[i], RSTV[i]);
      end
      chk8("pd", 8'h00, {2'b00, pd});
      wr(8'h14, 8'hFF);
      rd(ALARM_CFG_OFS, mdl[2]);
      // offset alarm: input 0 just above threshold, input 1 at it
      per_en = 2'b11;
      for (int c = 0; c < 4; c++) begin
         wr(ALARM_CFG_OFS, {1'b1, 2'(c), 2'(c), 3'b001});
         ofs[0] = OFS_W'(THR[c] + 1);
         ofs[1] = OFS_W'(THR[c]);
         repeat (2) cyc();
         chk1("alarm0", 1'b1, alarm[0]);
         chk1("alarm1", 1'b0, alarm[1]);
         ofs = '0;
         repeat (VT[c] - 2) cyc();
         chk1("alarm0", 1'b1, alarm[0]);
         repeat (6) cyc();
         chk1("alarm0", 1'b0, alarm[0]);
      end
      ofs = {10'h0C9, 10'h0C9};
      repeat (2) cyc();
      chk1("alarm1", 1'b1, alarm[1]);
      per_en[0] = 1'b0;
      repeat (2) cyc();
      chk1("alarm0", 1'b0, alarm[0]);
      chk1("alarm1", 1'b1, alarm[1]);
      per_en = 2'b11;
      repeat (2) cyc();
      wr(ALARM_CFG_OFS, 8'h79);
      repeat (2) cyc();
      chk1("alarm0", 1'b0, alarm[0]);
      chk1("alarm1", 1'b0, alarm[1]);
      ofs = '0;
      // lock one-shot over every interval code
      for (int c = 0; c < 8; c++) begin
         wr(ALARM_CFG_OFS, {5'b00101, 3'(c)});
         phase_slip = 1'b1;
         cyc();
         phase_slip = 1'b0;
         cyc();
         chk1("oneshot", 1'b1, os_act);
         repeat (LT[c] - 4) cyc();
         chk1("oneshot", 1'b1, os_act);
         repeat (6) cyc();
         chk1("oneshot", 1'b0, os_act);
      end
      // a second slip mid-interval extends the one-shot
      phase_slip = 1'b1;
      cyc();
      phase_slip = 1'b0;
      repeat (6) cyc();
      phase_slip = 1'b1;
      cyc();
      phase_slip = 1'b0;
      repeat (7) cyc();
      chk1("oneshot", 1'b1, os_act);
      repeat (6) cyc();
      chk1("oneshot", 1'b0, os_act);
      end_sim();
   end
endmodule

// >>> verilog/cba_clk_cfg.sv
// register bank for clock buffer power-down, offset alarm and lock one-shot
`timescale 1ns/100ps

// Function
// - Bit 3 of the output disable register powers down the second output buffer when 1.
// - Disabling the second output also powers down its low-speed divider.
// - Bit 2 of the output disable register powers down the first output buffer when 1.
// - Disabling the first output also powers down its low-speed divider.
// - Bit 1 of the input powerdown register disables the second input buffer when 1.
// - Bit 0 of the input powerdown register disables the first input buffer when 1.
// - Bit 7 of the alarm config register gates all offset alarms; at 1 per-input enables apply.
// - Bits 6:5 pick the offset threshold: 11-12, 48-49, 30 or 200 ppm.
// - Bits 4:3 pick how long an input stays good before its alarm clears: 2, 100, 200 ms, 13 s.
// - Bits 2:0 pick the lock one-shot interval from 106 ms down to 0.833 ms.
// - Each phase slip retriggers the lock one-shot.
// - The alarm config register resets to 0010 1100.
// - The input powerdown register resets to 0100 0000.
module cba_clk_cfg #(
   parameter logic [3:0][31:0] VALT_CYCLES  = cba_pkg::VALT_CYC,
   parameter logic [7:0][31:0] LOCK_ONESHOT_INTERVAL_CYCLES = cba_pkg::LOCK_ONESHOT_INTERVAL_CYC
) (
   // clock and reset
   input  wire logic                                clk_sys,
   input  wire logic                                reset,
   // register access from the host serial port
   input  wire cba_pkg::cba_req_type                reg_req,
   output logic [7:0]                               reg_rdata,
   output logic                                     reg_rvalid,
   // frequency monitor, on-chip, same clock
   input  wire logic [1:0]                          per_input_offset_enable,
   input  wire logic [1:0][cba_pkg::OFS_W-1:0]      offset_ppm,
   input  wire logic                                phase_slip,
   // controls and status
   output cba_pkg::cba_pd_type                      pd,
   output logic [1:0]                               frequency_offset_alarm,
   output logic                                     lock_oneshot_active
);
   import cba_pkg::*;

   // ---------------------------------------------------------------
   // register decode
   // ---------------------------------------------------------------
   logic [7:0] out_dis_ff;
   logic [7:0] in_pd_ff;
   logic [7:0] alarm_cfg_ff;
   logic [7:0] rdata_ff;
   logic       rvalid_ff;

   wire hit_out = reg_req.addr == OUT_DIS_OFS;
   wire hit_in  = reg_req.addr == IN_PD_OFS;
   wire hit_cfg = reg_req.addr == ALARM_CFG_OFS;

   // reserved bits are masked off so they keep their reset pattern
   wire [7:0] nxt_out_dis = (reg_req.wr && hit_out) ?
      ((out_dis_ff & ~OUT_DIS_WMASK) | (reg_req.wdata & OUT_DIS_WMASK)) : out_dis_ff;
   wire [7:0] nxt_in_pd = (reg_req.wr && hit_in) ?
      ((in_pd_ff & ~IN_PD_WMASK) | (reg_req.wdata & IN_PD_WMASK)) : in_pd_ff;
   wire [7:0] nxt_alarm_cfg = (reg_req.wr && hit_cfg) ?
      ((alarm_cfg_ff & ~ALARM_CFG_WMASK) | (reg_req.wdata & ALARM_CFG_WMASK)) : alarm_cfg_ff;

   // unmapped addresses read zero
   wire [7:0] nxt_rdata = hit_out ? out_dis_ff :
                          hit_in  ? in_pd_ff   :
                          hit_cfg ? alarm_cfg_ff : 8'h00;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         out_dis_ff   <= OUT_DIS_RST;
         in_pd_ff     <= IN_PD_RST;
         alarm_cfg_ff <= ALARM_CFG_RST;
         rdata_ff     <= 8'h00;
         rvalid_ff    <= 1'b0;
      end else begin
         out_dis_ff   <= nxt_out_dis;
         in_pd_ff     <= nxt_in_pd;
         alarm_cfg_ff <= nxt_alarm_cfg;
         rdata_ff     <= reg_req.rd ? nxt_rdata : rdata_ff;
         rvalid_ff    <= reg_req.rd;
      end
   end

   assign reg_rdata  = rdata_ff;
   assign reg_rvalid = rvalid_ff;

   // ---------------------------------------------------------------
   // power-down controls
   // ---------------------------------------------------------------
   // buffer and divider share one flop so they can never disagree
   assign pd.out2_buf_pd = out_dis_ff[OUT2_DIS_BIT];
   assign pd.out2_div_pd = out_dis_ff[OUT2_DIS_BIT];
   assign pd.out1_buf_pd = out_dis_ff[OUT1_DIS_BIT];
   assign pd.out1_div_pd = out_dis_ff[OUT1_DIS_BIT];
   assign pd.in2_pd      = in_pd_ff[IN2_PD_BIT];
   assign pd.in1_pd      = in_pd_ff[IN1_PD_BIT];

   // ---------------------------------------------------------------
   // frequency offset alarms
   // ---------------------------------------------------------------
   wire             glb_en    = alarm_cfg_ff[GLB_EN_BIT];
   wire [1:0]       thr_code  = alarm_cfg_ff[THR_LSB +: 2];
   wire [1:0]       valt_code = alarm_cfg_ff[VALT_LSB +: 2];
   wire [2:0]       lock_code = alarm_cfg_ff[LOCK_ONESHOT_INTERVAL_LSB +: 3];
   wire [OFS_W-1:0] thr_sel   = THR_PPM[thr_code];
   wire [31:0]      valt_sel  = VALT_CYCLES[valt_code];
   wire [31:0]      lock_sel  = LOCK_ONESHOT_INTERVAL_CYCLES[lock_code];

   logic [1:0] alarm_ff;
   logic [1:0] raw_bad;
   logic [1:0] valid_run;
   logic [1:0] nxt_alarm;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_in
         wire in_en = glb_en && per_input_offset_enable[gi];
         assign raw_bad[gi] = in_en && (offset_ppm[gi] > thr_sel);
         // a bad sample reloads the validation timer; alarm holds until it runs out or the input's enable drops
         cba_timer u_valid (
            .clk_sys (clk_sys),
            .reset   (reset),
            .load    (raw_bad[gi]),
            .period  (valt_sel),
            .running (valid_run[gi])
         );
         assign nxt_alarm[gi] = in_en && (raw_bad[gi] || (alarm_ff[gi] && valid_run[gi]));
      end
   endgenerate

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         alarm_ff <= 2'h0;
      end else begin
         alarm_ff <= nxt_alarm;
      end
   end

   assign frequency_offset_alarm = alarm_ff;

   // ---------------------------------------------------------------
   // lock one-shot
   // ---------------------------------------------------------------
   // a new interval code takes effect at the next slip, not mid-interval
   cba_timer u_lock (
      .clk_sys (clk_sys),
      .reset   (reset),
      .load    (phase_slip),
      .period  (lock_sel),
      .running (lock_oneshot_active)
   );

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   out2_disable_a: assert property (@(posedge clk_sys) disable iff (reset)
      reg_req.wr && hit_out |=> pd.out2_buf_pd == $past(reg_req.wdata[OUT2_DIS_BIT])
                                && pd.out2_div_pd == pd.out2_buf_pd)
      else $error("second output disable mismatch");
   out1_disable_a: assert property (@(posedge clk_sys) disable iff (reset)
      reg_req.wr && hit_out |=> pd.out1_buf_pd == $past(reg_req.wdata[OUT1_DIS_BIT])
                                && pd.out1_div_pd == pd.out1_buf_pd)
      else $error("first output disable mismatch");
   in2_powerdown_a: assert property (@(posedge clk_sys) disable iff (reset)
      reg_req.wr && hit_in |=> pd.in2_pd == $past(reg_req.wdata[IN2_PD_BIT]))
      else $error("second input powerdown mismatch");
   in1_powerdown_a: assert property (@(posedge clk_sys) disable iff (reset)
      reg_req.wr && hit_in |=> pd.in1_pd == $past(reg_req.wdata[IN1_PD_BIT]))
      else $error("first input powerdown mismatch");
   global_off_a: assert property (@(posedge clk_sys) disable iff (reset)
      !glb_en |=> frequency_offset_alarm == 2'h0)
      else $error("alarm raised while globally disabled");
   threshold_hit_a: assert property (@(posedge clk_sys) disable iff (reset)
      glb_en && per_input_offset_enable[0] && offset_ppm[0] > THR_PPM[thr_code]
      |=> frequency_offset_alarm[0])
      else $error("offset above threshold without alarm");
   valid_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
      $fell(raw_bad[0]) && glb_en && per_input_offset_enable[0] && valt_sel > 32'h0000_0002
      |=> frequency_offset_alarm[0])
      else $error("alarm cleared before validation time");
   oneshot_start_a: assert property (@(posedge clk_sys) disable iff (reset)
      phase_slip |=> lock_oneshot_active)
      else $error("one-shot not retriggered by slip");
   reset_value_a: assert property (@(posedge clk_sys) disable iff (reset)
      $past(reset) |-> alarm_cfg_ff == ALARM_CFG_RST && in_pd_ff == IN_PD_RST)
      else $error("bad reset value");
   reserved_bits_a: assert property (@(posedge clk_sys) disable iff (reset)
      (out_dis_ff & ~OUT_DIS_WMASK) == (OUT_DIS_RST & ~OUT_DIS_WMASK)
      && (in_pd_ff & ~IN_PD_WMASK) == (IN_PD_RST & ~IN_PD_WMASK))
      else $error("reserved bits changed");
   alarm_cause_a: assert property (@(posedge clk_sys) disable iff (reset)
      frequency_offset_alarm[1] |-> $past(glb_en && per_input_offset_enable[1]))
      else $error("alarm without enables");
   cfg_write_a: assert property (@(posedge clk_sys) disable iff (reset)
      reg_req.wr && hit_cfg |=> alarm_cfg_ff == $past(reg_req.wdata))
      else $error("alarm config write lost");
   unmapped_read_a: assert property (@(posedge clk_sys) disable iff (reset)
      reg_req.rd && !(hit_out || hit_in || hit_cfg) |=> reg_rvalid && reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   enable_drop_a: assert property (@(posedge clk_sys) disable iff (reset)
      (frequency_offset_alarm & ~$past(per_input_offset_enable)) == 2'h0)
      else $error("alarm kept after its enable dropped");
   threshold_hit1_a: assert property (@(posedge clk_sys) disable iff (reset)
      glb_en && per_input_offset_enable[1] && offset_ppm[1] > THR_PPM[thr_code]
      |=> frequency_offset_alarm[1])
      else $error("second input above threshold without alarm");
   alarm_rise_a: assert property (@(posedge clk_sys) disable iff (reset)
      $rose(frequency_offset_alarm[0]) |-> $past(raw_bad[0]))
      else $error("alarm raised without offset");
   oneshot_end_a: assert property (@(posedge clk_sys) disable iff (reset)
      $fell(lock_oneshot_active) |-> !$past(phase_slip))
      else $error("one-shot ended right after a slip");

   alarm_seen_c: cover property (@(posedge clk_sys) disable iff (reset)
      $rose(frequency_offset_alarm[0]));
   alarm_clear_c: cover property (@(posedge clk_sys) disable iff (reset)
      $fell(frequency_offset_alarm[0]) && glb_en);
   oneshot_end_c: cover property (@(posedge clk_sys) disable iff (reset)
      $fell(lock_oneshot_active));
   read_back_c: cover property (@(posedge clk_sys) disable iff (reset)
      reg_req.rd && hit_cfg);
   oneshot_code1_c: cover property (@(posedge clk_sys) disable iff (reset)
      phase_slip && lock_code == 3'h1);
endmodule

// >>> verilog/cba_timer.sv
// retriggerable down-counter used for validation and lock one-shot intervals
`timescale 1ns/100ps
module cba_timer (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset,
   // control
   input  wire logic        load,
   input  wire logic [31:0] period,
   // status
   output logic             running
);
   logic [31:0] cnt_ff;
   logic [31:0] nxt_cnt;
   logic        running_ff;
   wire         cnt_zero = (cnt_ff == 32'h0000_0000);

   assign nxt_cnt = load ? period : (cnt_zero ? cnt_ff : cnt_ff - 32'h0000_0001);
   assign running = running_ff;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cnt_ff     <= 32'h0000_0000;
         running_ff <= 1'b0;
      end else begin
         cnt_ff     <= nxt_cnt;
         running_ff <= (nxt_cnt != 32'h0000_0000);
      end
   end

   timer_load_a: assert property (@(posedge clk_sys) disable iff (reset)
      load && period > 32'h0000_0001 |=> running ##1 running)
      else $error("timer not running after load");
endmodule
